// >>> core/mtmr_top.sv
// Modulo timer: Avalon-MM registers, clock source selection, counter and overflow flag
// Contract
// - Eight-bit up-counter, free running or wrapping at the wrap limit.
// - Overflow interrupt request, enabled or disabled by software.
// - Source: bus clock, fixed clock rising, pin rising or pin falling.
// - Prescaler divides the source by 1 to 256 in powers of two.
// - Source codes 11 and 10 select the external timer clock pin.
// - Counter clear control bit returns the counter to zero.
// - Counter halt bit freezes counting while set.
// - Counting continues in wait mode so overflow can wake the processor.
// - In stop mode the timer is disabled and never wakes the system.
// - Waking from deep stop returns all timer state to reset values.
// - Light stop left by reset resets; left by interrupt keeps state.
// - Counting is suspended in debug mode and resumes afterwards.
// - Counter clear or wrap limit write acts as a timer reset.
// - External pin is synchronised to the bus clock before use.
// - Status/control: flag 7, enable 6, clear 5 write-only, halt 4.
// - Clock config: top two bits zero, source above prescale.
// - Count register is read-only; writes are ignored.
// - Wrap limit register is eight bits, readable and writable.
// - Flag sets on wrap to zero after the limit; enabled flag interrupts.
// - Flag clears by read-then-write-zero, counter clear, or limit write.
// - Reset sets halt, clears enable, source and prescale.
// - Prescale codes above 1000 divide by 256.
//
// Chosen here: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "mtmr_map.svh"
module mtmr_top
  import mtmr_pkg::*;
#(
  parameter int unsigned PS_STAGES = 8
) (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  input  wire logic [3:0]  AVS_BYTEENABLE,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // Clock sources
  input  wire logic        FIXED_FREQ_CLOCK,
  input  wire logic        EXT_TIMER_CLOCK_PIN,
  // Processor mode
  input  wire logic        STOP_MODE,
  input  wire logic        DEEP_STOP_WAKE,
  input  wire logic        DEBUG_ACTIVE,
  // Interrupt request
  output logic             OVERFLOW_IRQ
);
  import mtmr_pkg::*;

  // Register state
  logic             overflow_flag_r;
  logic             overflow_irq_enable_r;
  logic             counter_halt_r;
  mtmr_src_e        clock_source_select_r;
  logic [3:0]       prescale_select_r;
  mtmr_byte_t       count_r;
  mtmr_byte_t       count_nxt;
  mtmr_byte_t       wrap_limit_field_r;
  logic             flag_seen_r;
  mtmr_bus_e        bus_state_r;
  logic [31:0]      rdata_r;

  logic             soft_rst;
  logic             acc;
  logic             wr_sc;
  logic             wr_ck;
  logic             wr_mod;
  logic             rd_sc;
  logic             wr_lane0;
  logic             fixed_rise;
  logic             pin_rise;
  logic             pin_fall;
  logic             src_tick;
  logic             pre_tick;
  logic             cnt_tick;
  logic             wrap;
  logic             hw_rst;

  // Deep-stop wake is treated like a full reset of every timer flop except the bus sequencer and read data, which only RST clears
  assign hw_rst = RST || DEEP_STOP_WAKE;

  // One cycle of wait on every access, then the answer is given
  assign acc      = (AVS_READ || AVS_WRITE) && (bus_state_r == MTMR_BUS_IDLE);
  assign wr_lane0 = AVS_WRITE && acc && AVS_BYTEENABLE[0];
  assign wr_sc    = wr_lane0 && (AVS_ADDRESS == `MTMR_OFF_STATUS_CONTROL);
  assign wr_ck    = wr_lane0 && (AVS_ADDRESS == `MTMR_OFF_CLOCK_CONFIG);
  assign wr_mod   = wr_lane0 && (AVS_ADDRESS == `MTMR_OFF_WRAP_LIMIT);
  assign rd_sc    = AVS_READ && acc && (AVS_ADDRESS == `MTMR_OFF_STATUS_CONTROL);
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && (bus_state_r == MTMR_BUS_IDLE);

  // Counter clear write or any limit write with byte lane 0 enabled is a timer reset
  assign soft_rst = (wr_sc && AVS_WRITEDATA[`MTMR_SC_CLR_BIT]) || wr_mod;

  // Answer sequencer: the request is taken in IDLE and answered in DONE
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      bus_state_r <= MTMR_BUS_IDLE;
    end else begin
      case (bus_state_r)
        MTMR_BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            bus_state_r <= MTMR_BUS_DONE;
          end
        end
        MTMR_BUS_DONE: begin
          bus_state_r <= MTMR_BUS_IDLE;
        end
        default: begin
          bus_state_r <= MTMR_BUS_IDLE;
        end
      endcase
    end
  end

  // Read data registered when the request is taken; unmapped reads give zero
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_r <= 32'h0000_0000;
    end else if (AVS_READ && acc) begin
      case (AVS_ADDRESS)
        `MTMR_OFF_STATUS_CONTROL: rdata_r <= {24'h00_0000, overflow_flag_r,
                                    overflow_irq_enable_r, 1'b0, counter_halt_r,
                                    4'h0};
        `MTMR_OFF_CLOCK_CONFIG:   rdata_r <= {24'h00_0000, 2'b00,
                                    clock_source_select_r, prescale_select_r};
        `MTMR_OFF_COUNT_VALUE:    rdata_r <= {24'h00_0000, count_r};
        `MTMR_OFF_WRAP_LIMIT:     rdata_r <= {24'h00_0000, wrap_limit_field_r};
        default:                  rdata_r <= 32'h0000_0000;
      endcase
    end
  end
  assign AVS_READDATA = rdata_r;

  // Control bits of status/control
  always_ff @(posedge REF_CLK) begin
    if (hw_rst) begin
      overflow_irq_enable_r <= 1'b0;
      counter_halt_r        <= `MTMR_RST_HALT;
    end else if (wr_sc) begin
      overflow_irq_enable_r <= AVS_WRITEDATA[`MTMR_SC_IRQEN_BIT];
      counter_halt_r        <= AVS_WRITEDATA[`MTMR_SC_HALT_BIT];
    end
  end

  // Clock configuration; changes never clear the count
  always_ff @(posedge REF_CLK) begin
    if (hw_rst) begin
      clock_source_select_r <= mtmr_src_e'(`MTMR_RST_SRC);
      prescale_select_r     <= `MTMR_RST_PS;
    end else if (wr_ck) begin
      clock_source_select_r <= mtmr_src_e'(AVS_WRITEDATA[`MTMR_CK_SRC_HI:`MTMR_CK_SRC_LO]);
      prescale_select_r     <= AVS_WRITEDATA[`MTMR_CK_PS_HI:`MTMR_CK_PS_LO];
    end
  end

  // Wrap limit register
  always_ff @(posedge REF_CLK) begin
    if (hw_rst) begin
      wrap_limit_field_r <= `MTMR_RST_LIMIT;
    end else if (wr_mod) begin
      wrap_limit_field_r <= AVS_WRITEDATA[7:0];
    end
  end

  // Fixed clock is an outside level, so it too passes the three-stage filter
  mtmr_pin_sync u_fixed_sync (
    .REF_CLK (REF_CLK),
    .RST     (hw_rst),
    .pin_in  (FIXED_FREQ_CLOCK),
    .rise_o  (fixed_rise),
    .fall_o  ()
  );

  mtmr_pin_sync u_pin_sync (
    .REF_CLK (REF_CLK),
    .RST     (hw_rst),
    .pin_in  (EXT_TIMER_CLOCK_PIN),
    .rise_o  (pin_rise),
    .fall_o  (pin_fall)
  );

  // Source tick mux; bus clock ticks every cycle
  always_comb begin
    case (clock_source_select_r)
      MTMR_SRC_BUS:   src_tick = 1'b1;
      MTMR_SRC_FIXED: src_tick = fixed_rise;
      MTMR_SRC_PINF:  src_tick = pin_fall;
      MTMR_SRC_PINR:  src_tick = pin_rise;
      default:        src_tick = 1'b1;
    endcase
  end

  mtmr_prescaler #(
    .STAGES (PS_STAGES)
  ) u_prescaler (
    .REF_CLK    (REF_CLK),
    .RST        (hw_rst),
    .clear_i    (soft_rst),
    .src_tick_i (src_tick && !counter_halt_r && !STOP_MODE && !DEBUG_ACTIVE),
    .ps_i       (prescale_select_r),
    .tick_o     (pre_tick)
  );

  // Stop and debug hold the count; wait mode is not a gate, so it keeps counting
  assign cnt_tick = pre_tick && !counter_halt_r && !STOP_MODE && !DEBUG_ACTIVE;
  // Limit zero wraps from ff, so all 256 states are visited
  assign wrap     = (wrap_limit_field_r == 8'h00) ? (count_r == 8'hFF)
                                                  : (count_r == wrap_limit_field_r);
  assign count_nxt = wrap ? 8'h00 : count_r + 8'h01;

  // Counter
  always_ff @(posedge REF_CLK) begin
    if (hw_rst || soft_rst) begin
      count_r <= `MTMR_RST_COUNT;
    end else if (cnt_tick) begin
      count_r <= count_nxt;
    end
  end

  // Read of status/control with the flag set arms the clear by writing zero
  always_ff @(posedge REF_CLK) begin
    if (hw_rst || soft_rst) begin
      flag_seen_r <= 1'b0;
    end else if (rd_sc && overflow_flag_r) begin
      flag_seen_r <= 1'b1;
    end else if (wr_sc) begin
      flag_seen_r <= 1'b0;
    end
  end

  // Overflow flag; a wrap wins over a write-zero clear in the same cycle, a timer reset wins over a wrap
  always_ff @(posedge REF_CLK) begin
    if (hw_rst) begin
      overflow_flag_r <= 1'b0;
    end else if (cnt_tick && wrap && !soft_rst) begin
      overflow_flag_r <= 1'b1;
    end else if (soft_rst) begin
      overflow_flag_r <= 1'b0;
    end else if (wr_sc && flag_seen_r && !AVS_WRITEDATA[`MTMR_SC_OVF_BIT]) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // Interrupt request is masked off in stop so it never acts as a wake-up
  assign OVERFLOW_IRQ = overflow_flag_r && overflow_irq_enable_r && !STOP_MODE;

  // Flag sets exactly one cycle after a counting wrap
  AST_FLAG_ON_WRAP: assert property (@(posedge REF_CLK) disable iff (hw_rst)
    (cnt_tick && wrap && !soft_rst) |=> overflow_flag_r)
    else $error("overflow flag missed a wrap");

  // Halt freezes the count
  AST_HALT_HOLDS: assert property (@(posedge REF_CLK) disable iff (hw_rst)
    (counter_halt_r && !soft_rst) |=> $stable(count_r))
    else $error("count moved while halted");

  // Debug and stop suspend counting
  AST_SUSPEND: assert property (@(posedge REF_CLK) disable iff (hw_rst)
    ((DEBUG_ACTIVE || STOP_MODE) && !soft_rst) |=> $stable(count_r))
    else $error("count moved while suspended");

  // Timer reset zeroes count and flag
  AST_SOFT_RESET: assert property (@(posedge REF_CLK) disable iff (hw_rst)
    soft_rst |=> (count_r == 8'h00) && !overflow_flag_r)
    else $error("timer reset did not clear count and flag");

  // Writes to the count register do nothing
  AST_COUNT_RO: assert property (@(posedge REF_CLK) disable iff (hw_rst)
    (wr_lane0 && AVS_ADDRESS == `MTMR_OFF_COUNT_VALUE && !cnt_tick) |=> $stable(count_r))
    else $error("count register took a write");

  // Bus clock, divide by 1, running: count advances each cycle
  AST_BUS_COUNT: assert property (@(posedge REF_CLK) disable iff (hw_rst)
    (clock_source_select_r == MTMR_SRC_BUS && prescale_select_r == 4'h0 && !counter_halt_r
     && !STOP_MODE && !DEBUG_ACTIVE && !soft_rst && !wrap) |=> (count_r == $past(count_r) + 8'h01))
    else $error("count did not advance on bus clock");

  // Limit zero wraps only from ff
  AST_FREE_RUN: assert property (@(posedge REF_CLK) disable iff (hw_rst)
    (cnt_tick && wrap_limit_field_r == 8'h00 && count_r == 8'hFE && !soft_rst)
    |=> (count_r == 8'hFF))
    else $error("free run wrapped early");

  // Read of status/control shows the reserved bits as zero
  sequence s_sc_read;
    rd_sc ##1 (bus_state_r == MTMR_BUS_DONE);
  endsequence
  AST_SC_LAYOUT: assert property (@(posedge REF_CLK) disable iff (hw_rst)
    s_sc_read |-> (AVS_READDATA[3:0] == 4'h0) && !AVS_READDATA[5])
    else $error("status/control reserved bits not zero");

  // Interrupt requires flag and enable
  AST_IRQ: assert property (@(posedge REF_CLK) disable iff (hw_rst)
    OVERFLOW_IRQ |-> (overflow_flag_r && overflow_irq_enable_r))
    else $error("interrupt without flag and enable");
endmodule // mtmr_top
`default_nettype wire

// >>> core/mtmr_map.svh
// Register offsets, field positions, reset values and timing counts of the modulo timer
`ifndef MTMR_MAP_SVH
`define MTMR_MAP_SVH

// Register byte offsets on the 32-bit bus, one word each
`define MTMR_OFF_STATUS_CONTROL 4'h0
`define MTMR_OFF_CLOCK_CONFIG   4'h4
`define MTMR_OFF_COUNT_VALUE    4'h8
`define MTMR_OFF_WRAP_LIMIT     4'hC

// Status/control field positions
`define MTMR_SC_OVF_BIT   7
`define MTMR_SC_IRQEN_BIT 6
`define MTMR_SC_CLR_BIT   5
`define MTMR_SC_HALT_BIT  4

// Clock configuration field positions
`define MTMR_CK_SRC_HI 5
`define MTMR_CK_SRC_LO 4
`define MTMR_CK_PS_HI  3
`define MTMR_CK_PS_LO  0

// Reset values
`define MTMR_RST_HALT  1'b1
`define MTMR_RST_SRC   2'h0
`define MTMR_RST_PS    4'h0
`define MTMR_RST_COUNT 8'h00
`define MTMR_RST_LIMIT 8'h00

// Largest prescale code; codes above it divide by 256 too
`define MTMR_PS_MAX 4'h8

// Register read latency of the bus slave in clock cycles
`define MTMR_BUS_LATENCY 1

`endif

// >>> core/mtmr_pkg.sv
// Types shared by the modulo timer design files
package mtmr_pkg;

  // Prescaler input source codes
  typedef enum logic [1:0] {
    MTMR_SRC_BUS   = 2'b00,
    MTMR_SRC_FIXED = 2'b01,
    MTMR_SRC_PINF  = 2'b10,
    MTMR_SRC_PINR  = 2'b11
  } mtmr_src_e;

  // Bus slave answer states
  typedef enum logic [0:0] {
    MTMR_BUS_IDLE = 1'b0,
    MTMR_BUS_DONE = 1'b1
  } mtmr_bus_e;

  typedef logic [7:0] mtmr_byte_t;

endpackage : mtmr_pkg

// >>> core/mtmr_pin_sync.sv
// Three-stage synchroniser with edge detection for the external timer clock pin
`timescale 1ns/1ps
`default_nettype none
module mtmr_pin_sync (
  // Clock and reset
  input  wire logic REF_CLK,
  input  wire logic RST,
  // Pin and edges
  input  wire logic pin_in,
  output logic      rise_o,
  output logic      fall_o
);
  logic [2:0] sync_r;
  logic       level_r;

  // Stage 0 is read only by stage 1
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      sync_r <= 3'b000;
    end else begin
      sync_r <= {sync_r[1:0], pin_in};
    end
  end

  // A change counts once stages 1 and 2 agree
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      level_r <= 1'b0;
    end else if (sync_r[1] == sync_r[2]) begin
      level_r <= sync_r[2];
    end
  end

  assign rise_o = (sync_r[1] == sync_r[2]) && sync_r[2] && !level_r;
  assign fall_o = (sync_r[1] == sync_r[2]) && !sync_r[2] && level_r;
endmodule // mtmr_pin_sync
`default_nettype wire

// >>> core/mtmr_prescaler.sv
// Power-of-two prescaler that turns source ticks into counter ticks
`timescale 1ns/1ps
`default_nettype none
`include "mtmr_map.svh"
module mtmr_prescaler #(
  parameter int unsigned STAGES = 8
) (
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RST,
  // Control
  input  wire logic       clear_i,
  input  wire logic       src_tick_i,
  input  wire logic [3:0] ps_i,
  // Output tick
  output logic            tick_o
);
  logic [STAGES-1:0] div_r;
  logic [3:0]        sel;

  // Codes above the largest one fall back to the slowest ratio
  assign sel = (ps_i > `MTMR_PS_MAX) ? `MTMR_PS_MAX : ps_i;

  // Ripple divider advanced only by source ticks
  always_ff @(posedge REF_CLK) begin
    if (RST || clear_i) begin
      div_r <= '0;
    end else if (src_tick_i) begin
      div_r <= div_r + 1'b1;
    end
  end

  // Tick when the low sel bits are all ones, i.e. every 2^sel source ticks
  always_comb begin
    tick_o = src_tick_i;
    for (int i = 0; i < STAGES; i++) begin
      if (i < sel) begin
        tick_o = tick_o && div_r[i];
      end
    end
  end
endmodule // mtmr_prescaler
`default_nettype wire

// >>> test/mtmr_ext_clk.sv
// Behavioural external clock source that drives the timer clock pin in bursts
`timescale 1ns/1ps
`default_nettype none
module mtmr_ext_clk #(
  parameter int HALF = 4
) (
  // Clock
  input  wire logic       REF_CLK,
  // Burst request
  input  wire logic       go_i,
  input  wire logic [8:0] n_i,
  // Pin and status
  output logic            pin_o,
  output logic            busy_o
);
  logic [8:0] left_r;
  int         ph_r;

  initial begin
    pin_o  = 1'b0;
    left_r = 9'h000;
    ph_r   = 0;
  end

  // Whole periods only; the pin rests low outside a burst
  always @(posedge REF_CLK) begin
    if (go_i) begin
      left_r <= n_i;
      ph_r   <= 0;
    end else if (left_r != 9'h000) begin
      ph_r <= ph_r + 1;
      if (ph_r == HALF - 1) begin  // Period 2*HALF cycles, slower than a quarter
        ph_r  <= 0;
        pin_o <= ~pin_o;
        if (pin_o) left_r <= left_r - 9'h001;
      end
    end
  end

  assign busy_o = (left_r != 9'h000);
endmodule // mtmr_ext_clk
`default_nettype wire

// >>> test/tb_modulo_timer_8bit.sv
// Self-checking testbench of the modulo timer, register accesses over Avalon-MM
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL t=%0t got %h expected %h", $time, g, e); end end
module tb_modulo_timer_8bit;
  import mtmr_pkg::*;
  logic        REF_CLK, RST, AVS_READ, AVS_WRITE, STOP_MODE, DEEP_STOP_WAKE, DEBUG_ACTIVE;
  logic [3:0]  AVS_ADDRESS, AVS_BYTEENABLE;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  logic        AVS_WAITREQUEST, OVERFLOW_IRQ, pin_w, fix_w, pin_busy, fix_busy;
  logic        pin_go, fix_go;
  logic [8:0]  burst_n;
  int          err_total, n_tests, k;
  mtmr_byte_t  q;

  mtmr_top #(.PS_STAGES(8)) uut (.REF_CLK(REF_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .FIXED_FREQ_CLOCK(fix_w),
    .EXT_TIMER_CLOCK_PIN(pin_w), .STOP_MODE(STOP_MODE), .DEEP_STOP_WAKE(DEEP_STOP_WAKE),
    .DEBUG_ACTIVE(DEBUG_ACTIVE), .OVERFLOW_IRQ(OVERFLOW_IRQ));
  // Two independent sources: the pin and the fixed-frequency input
  mtmr_ext_clk #(.HALF(4)) pin_src (.REF_CLK(REF_CLK), .go_i(pin_go), .n_i(burst_n),
    .pin_o(pin_w), .busy_o(pin_busy));
  mtmr_ext_clk #(.HALF(5)) fix_src (.REF_CLK(REF_CLK), .go_i(fix_go), .n_i(burst_n),
    .pin_o(fix_w), .busy_o(fix_busy));

  // Clock generator, 100 MHz
  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // One bus cycle; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input mtmr_byte_t d);
    int i;
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= w;
    AVS_READ      <= ~w;
    AVS_WRITEDATA <= {24'h00_0000, d};
    for (i = 0; i < 50; i++) begin
      @(posedge REF_CLK);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (i == 50) begin
      err_total++;
      report_and_stop();
    end
    q = AVS_READDATA[7:0];
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge REF_CLK);
  endtask

  task automatic wr(input logic [3:0] a, input mtmr_byte_t d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [3:0] a, input mtmr_byte_t e);
    bus(1'b0, a, 8'h00);
    `CHK(q, e)
  endtask

  // Interrupt line is looked at mid-cycle, where it has settled
  task automatic irq_chk(input logic e);
    @(negedge REF_CLK);
    `CHK(OVERFLOW_IRQ, e)
    @(posedge REF_CLK);
  endtask

  // Burst of n source periods, then time for the synchroniser and counter
  task automatic emit(input logic fixed, input int n);
    int i;
    burst_n <= n[8:0];
    if (fixed) fix_go <= 1'b1;
    else pin_go <= 1'b1;
    @(posedge REF_CLK);
    pin_go <= 1'b0;
    fix_go <= 1'b0;
    @(posedge REF_CLK);
    for (i = 0; i < 6000 && (pin_busy || fix_busy); i++) @(posedge REF_CLK);
    if (i == 6000) begin
      err_total++;
      report_and_stop();
    end
    repeat (8) @(posedge REF_CLK);
  endtask

  initial begin
    err_total = 0;
    n_tests = 0;
    RST = 1'b1;
    {AVS_READ, AVS_WRITE, STOP_MODE, DEEP_STOP_WAKE, DEBUG_ACTIVE} = 5'h00;
    {pin_go, fix_go} = 2'h0;
    burst_n = 9'h000;
    AVS_ADDRESS = 4'h0;
    AVS_WRITEDATA = 32'h0000_0000;
    AVS_BYTEENABLE = 4'hF;
    repeat (4) @(posedge REF_CLK);
    RST <= 1'b0;
    @(posedge REF_CLK);
    // Reset values and access kinds
    rd_chk(4'h0, 8'h10);
    rd_chk(4'h4, 8'h00);
    rd_chk(4'h8, 8'h00);
    rd_chk(4'hC, 8'h00);
    wr(4'h4, 8'hFF);
    rd_chk(4'h4, 8'h3F);
    wr(4'h8, 8'h55);
    rd_chk(4'h8, 8'h00);
    AVS_BYTEENABLE <= 4'h0;
    wr(4'hC, 8'h77);
    AVS_BYTEENABLE <= 4'hF;
    rd_chk(4'hC, 8'h00);
    wr(4'hC, 8'hA5);
    rd_chk(4'hC, 8'hA5);
    rd_chk(4'h2, 8'h00);
    wr(4'h0, 8'hF0);
    rd_chk(4'h0, 8'h50);
    // Every prescale code on pin rising edges, free running
    wr(4'hC, 8'h00);
    for (k = 0; k < 16; k++) begin
      wr(4'h4, {4'h3, k[3:0]});
      wr(4'h0, 8'h20);
      emit(1'b0, 256);
      rd_chk(4'h8, (k >= 8) ? 8'h01 : 8'((256 >> k) & 255));
      rd_chk(4'h0, (k == 0) ? 8'h80 : 8'h00);
    end
    // Pin falling edges and the fixed-frequency clock
    wr(4'h4, 8'h20);
    wr(4'h0, 8'h20);
    emit(1'b0, 5);
    rd_chk(4'h8, 8'h05);
    wr(4'h4, 8'h10);
    wr(4'h0, 8'h20);
    emit(1'b1, 3);
    rd_chk(4'h8, 8'h03);
    // Wrap at limit 3, flag and interrupt
    wr(4'h4, 8'h30);
    wr(4'hC, 8'h03);
    wr(4'h0, 8'h20);
    emit(1'b0, 4);
    rd_chk(4'h8, 8'h00);
    wr(4'h0, 8'h40);
    irq_chk(1'b1);
    rd_chk(4'h0, 8'hC0);
    STOP_MODE <= 1'b1;
    irq_chk(1'b0);
    emit(1'b0, 2);
    rd_chk(4'h8, 8'h00);
    STOP_MODE <= 1'b0;
    wr(4'h0, 8'h40);
    rd_chk(4'h0, 8'h40);
    irq_chk(1'b0);
    // Debug suspend and resume, then limit write as a timer reset
    DEBUG_ACTIVE <= 1'b1;
    emit(1'b0, 2);
    rd_chk(4'h8, 8'h00);
    DEBUG_ACTIVE <= 1'b0;
    emit(1'b0, 2);
    rd_chk(4'h8, 8'h02);
    wr(4'hC, 8'h03);
    rd_chk(4'h8, 8'h00);
    // Halt freezes, clear returns to zero
    wr(4'h0, 8'h10);
    emit(1'b0, 2);
    rd_chk(4'h8, 8'h00);
    wr(4'h0, 8'h00);
    emit(1'b0, 1);
    rd_chk(4'h8, 8'h01);
    wr(4'h0, 8'h20);
    rd_chk(4'h8, 8'h00);
    // Bus clock source counts every cycle
    wr(4'h4, 8'h00);
    repeat (8) @(posedge REF_CLK);
    rd_chk(4'h0, 8'h80);
    // Deep stop wake restores reset state
    DEEP_STOP_WAKE <= 1'b1;
    @(posedge REF_CLK);
    DEEP_STOP_WAKE <= 1'b0;
    @(posedge REF_CLK);
    rd_chk(4'h0, 8'h10);
    rd_chk(4'h4, 8'h00);
    rd_chk(4'hC, 8'h00);
    report_and_stop();
  end
endmodule // tb_modulo_timer_8bit
`default_nettype wire
